// File: src/dbs_pkg.sv
package dbs_pkg;

    // x18 part: two 9-bit byte lanes; the x8 part uses 8/4 (nybble lanes)
    localparam int DATA_W    = 18;
    localparam int LANE_W    = 9;
    localparam int LANES     = DATA_W / LANE_W;
    localparam int BEATS     = 2;
    localparam int WORD_W    = DATA_W * BEATS;
    localparam int MASK_W    = LANES * BEATS;
    localparam int ADDR_W    = 6;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int BUF_DEPTH = 2;

    // one link clock period is two cycles of the 5 ns system clock
    localparam real CLK_NS   = 5.0;
    localparam int  K_CLKS   = 2;
    localparam real K_NS     = CLK_NS * K_CLKS;

    // read data follows the command by this many link periods
    localparam int RD_LAT_K  = 2;
    // link periods a write must wait after a read so the bus can turn
    localparam int RD_WR_GAP = 2;

    // values after reset
    localparam logic K_RST  = 1'h0;
    localparam logic KN_RST = 1'h1;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_BEAT1 = 2'b01,
        BUS_BEAT2 = 2'b10
    } dbs_bus_t;

endpackage : dbs_pkg

// File: src/dbs_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dbs_if;
    logic                          k;
    logic                          k_n;
    logic                          load_n;
    logic                          read_not_write;
    logic [dbs_pkg::ADDR_W-1:0]    sync_addr_inputs;
    logic [dbs_pkg::LANES-1:0]     byte_write_mask_n;
    logic                          dll_disable_n;
    logic                          termination_enable;
    logic                          echo_clock_out;
    logic                          read_valid_out;
    logic [dbs_pkg::DATA_W-1:0]    dq_host;
    logic                          dq_host_oe;
    logic [dbs_pkg::DATA_W-1:0]    dq_dev;
    logic                          dq_dev_oe;
    logic [dbs_pkg::DATA_W-1:0]    dq;

    // shared data wire; an undriven bus reads as zero
    assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : '0);

    modport ctl (
        output k, k_n, load_n, read_not_write, sync_addr_inputs,
        output byte_write_mask_n, dll_disable_n, termination_enable,
        output dq_host, dq_host_oe,
        input  dq, echo_clock_out, read_valid_out
    );

    modport mem (
        input  k, k_n, load_n, read_not_write, sync_addr_inputs,
        input  byte_write_mask_n, dll_disable_n, termination_enable, dq,
        output dq_dev, dq_dev_oe, echo_clock_out, read_valid_out
    );
endinterface : dbs_if
`default_nettype wire

// File: src/dbs_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module dbs_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o,
    output logic [1:0]        count_o
);
    logic [W-1:0] e1;
    logic         v1;
    logic         push;
    logic         pop;

    // head entry is the output register, second entry absorbs a stall
    assign in_ready_o = ~v1;
    assign push       = in_valid_i & ~v1;
    assign pop        = out_valid_o & out_ready_i;
    assign count_o    = {1'h0, out_valid_o} + {1'h0, v1};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_valid_o <= 1'h0;
            v1          <= 1'h0;
            out_data_o  <= '0;
            e1          <= '0;
        end else if (pop) begin
            if (v1) begin
                out_data_o <= e1;
                v1         <= 1'h0;
            end else begin
                out_valid_o <= push;
                out_data_o  <= in_data_i;
            end
        end else if (push) begin
            if (!out_valid_o) begin
                out_valid_o <= 1'h1;
                out_data_o  <= in_data_i;
            end else begin
                v1 <= 1'h1;
                e1 <= in_data_i;
            end
        end
    end
endmodule : dbs_buf2
`default_nettype wire

// File: src/dbs_sram_dev.sv
// Behaviour
// - address, load, direction sampled on clock rise
// - load low, direction high is a read
// - every command moves exactly two data beats
// - controller may issue a command every period
// - deselect pipelined like read, then bus released
// - load high takes no command, deselects after bursts
// - write data beat one one period later
// - write beat two on next inverted-clock rise
// - masks sampled with their data beat
// - high mask keeps the stored lane unchanged
// - each lane of each beat masks independently
// - one address holds a two-beat word
// - narrow variant uses nybble lanes, same masking
// - dll_disable_n low turns the delay loop off
// - mask n covers lane n of data
// - write or idle releases drivers two periods later
`timescale 1ns/100ps
`default_nettype none
module dbs_sram_dev (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    dbs_if.mem        link,
    output logic      dll_active_o,
    output logic      dq_term_on_o
);
    localparam int DW = dbs_pkg::DATA_W;
    localparam int LW = dbs_pkg::LANE_W;
    localparam int AW = dbs_pkg::ADDR_W;
    localparam int WW = dbs_pkg::WORD_W;
    localparam int LN = dbs_pkg::LANES;
    localparam int MW = dbs_pkg::MASK_W;

    // one array word is the whole two-beat burst of one address
    logic [WW-1:0]  mem [dbs_pkg::MEM_DEPTH];

    logic           k_q;
    logic           kn_q;
    logic           k_rise;
    logic           kn_rise;

    logic           s1_vld;
    logic           s1_wr;
    logic [AW-1:0]  s1_addr;
    logic           s2_vld;
    logic           s2_wr;
    logic [AW-1:0]  s2_addr;
    logic [AW-1:0]  s3_addr;
    logic           s2_rd;

    logic [DW-1:0]  wbeat1;
    logic [LN-1:0]  wmask1;
    logic [WW-1:0]  cur_word;
    logic [WW-1:0]  beat_data;
    logic [MW-1:0]  beat_mask;
    logic [WW-1:0]  next_word;
    logic           rd_beat2;

    // edge detect on the two link clocks; both sampled every cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            k_q  <= dbs_pkg::K_RST;
            kn_q <= dbs_pkg::KN_RST;
        end else begin
            k_q  <= link.k;
            kn_q <= link.k_n;
        end
    end

    assign k_rise  = link.k & ~k_q;
    assign kn_rise = link.k_n & ~kn_q;

    // command capture: a high load takes nothing and the slot idles
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_vld  <= 1'h0;
            s1_wr   <= 1'h0;
            s1_addr <= '0;
        end else if (k_rise) begin
            s1_addr <= link.sync_addr_inputs;
            s1_vld  <= ~link.load_n;
            s1_wr   <= ~link.read_not_write;
        end
    end

    // later stages; a deselect walks down the pipe like a read does
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s2_vld  <= 1'h0;
            s2_wr   <= 1'h0;
            s2_addr <= '0;
            s3_addr <= '0;
        end else if (k_rise) begin
            s2_vld  <= s1_vld;
            s2_wr   <= s1_wr;
            s2_addr <= s1_addr;
            s3_addr <= s2_addr;
        end
    end

    assign s2_rd = s2_vld & ~s2_wr;

    // first write beat arrives one period after its command
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wbeat1 <= '0;
            wmask1 <= '1;
        end else if (k_rise && s1_vld && s1_wr) begin
            wbeat1 <= link.dq;
            wmask1 <= link.byte_write_mask_n;
        end
    end

    assign cur_word  = mem[s2_addr];
    assign beat_data = {link.dq, wbeat1};
    assign beat_mask = {link.byte_write_mask_n, wmask1};

    // per lane of each beat: a high mask keeps what is stored
    for (genvar i = 0; i < MW; i++) begin : g_lane
        assign next_word[i*LW +: LW] = beat_mask[i] ?
                                       cur_word[i*LW +: LW] :
                                       beat_data[i*LW +: LW];
    end

    // whole burst commits at once with the second beat
    always_ff @(posedge clk_i) begin
        if (kn_rise && s2_vld && s2_wr) begin
            mem[s2_addr] <= next_word;
        end
    end

    // read drive; beat two is read half a period later, from the address held in s3_addr
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.dq_dev         <= '0;
            link.dq_dev_oe      <= 1'h0;
            link.read_valid_out <= 1'h0;
            rd_beat2            <= 1'h0;
        end else if (k_rise) begin
            if (s2_rd) begin
                link.dq_dev         <= cur_word[DW-1:0];
                link.dq_dev_oe      <= 1'h1;
                link.read_valid_out <= 1'h1;
                rd_beat2            <= 1'h1;
            end else begin
                link.dq_dev         <= '0;
                link.dq_dev_oe      <= 1'h0;
                link.read_valid_out <= 1'h0;
                rd_beat2            <= 1'h0;
            end
        end else if (kn_rise && rd_beat2) begin
            // beat two is the upper half of the same word
            link.dq_dev <= mem[s3_addr][WW-1:DW];
            rd_beat2    <= 1'h0;
        end
    end

    // echo clock follows the input clock by one cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.echo_clock_out <= 1'h0;
        end else begin
            link.echo_clock_out <= link.k;
        end
    end

    // delay loop state; only a level, the loop itself is analog
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dll_active_o <= 1'h0;
        end else begin
            dll_active_o <= link.dll_disable_n;
        end
    end

    // termination drops half a period before and after read driving,
    // so the two ends never both load an undriven wire for long
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dq_term_on_o <= 1'h0;
        end else if (kn_rise) begin
            dq_term_on_o <= link.termination_enable & ~s2_rd &
                            ~link.dq_dev_oe;
        end
    end
endmodule : dbs_sram_dev
`default_nettype wire

// File: src/dbs_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module dbs_ctl (
    input  wire logic                        clk_i,
    input  wire logic                        rstn_i,
    dbs_if.ctl                               link,
    input  wire logic                        req_valid_i,
    input  wire logic                        req_write_i,
    input  wire logic [dbs_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [dbs_pkg::WORD_W-1:0]  req_wdata_i,
    input  wire logic [dbs_pkg::MASK_W-1:0]  req_mask_n_i,
    input  wire logic                        dll_enable_i,
    input  wire logic                        odt_enable_i,
    output logic                             req_ready_o,
    output logic                             rsp_valid_o,
    output logic [dbs_pkg::WORD_W-1:0]       rsp_data_o,
    input  wire logic                        rsp_ready_i
);
    localparam int DW = dbs_pkg::DATA_W;
    localparam int WW = dbs_pkg::WORD_W;
    localparam int LN = dbs_pkg::LANES;
    localparam int MW = dbs_pkg::MASK_W;

    logic              issue;
    logic              take;
    logic              take_rd;
    logic              take_wr;
    logic [1:0]        gap;
    logic [1:0]        pend;
    logic [1:0]        buf_cnt;
    logic [2:0]        credit_use;
    logic              wpend;
    logic [WW-1:0]     wdata;
    logic [MW-1:0]     wmask;
    logic [DW-1:0]     hi_data;
    logic [LN-1:0]     hi_mask;
    dbs_pkg::dbs_bus_t bus;
    logic              hb;
    logic [DW-1:0]     lo_beat;
    logic              push;

    // a command goes out on the cycle the link clock rises
    assign issue      = ~link.k;
    assign take       = issue & req_valid_i & req_ready_o;
    assign take_rd    = take & ~req_write_i;
    assign take_wr    = take & req_write_i;
    assign push       = link.read_valid_out & hb;
    assign credit_use = {1'h0, pend} + {1'h0, buf_cnt};

    // link clocks made by dividing the system clock by two
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.k   <= dbs_pkg::K_RST;
            link.k_n <= dbs_pkg::KN_RST;
        end else begin
            link.k   <= ~link.k;
            link.k_n <= ~link.k_n;
        end
    end

    // command pins; an idle slot is a deselect
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.load_n           <= 1'h1;
            link.read_not_write   <= 1'h1;
            link.sync_addr_inputs <= '0;
        end else if (issue) begin
            link.load_n <= ~take;
            if (take) begin
                link.read_not_write   <= ~req_write_i;
                link.sync_addr_inputs <= req_addr_i;
            end
        end
    end

    // static pins follow the user levels
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.dll_disable_n      <= 1'h0;
            link.termination_enable <= 1'h0;
        end else begin
            link.dll_disable_n      <= dll_enable_i;
            link.termination_enable <= odt_enable_i;
        end
    end

    // ready is decided one cycle ahead; reads need buffer room for the
    // return, writes wait out the read turnaround so drivers never clash
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'h0;
        end else if (issue) begin
            req_ready_o <= 1'h0;
        end else if (req_write_i) begin
            req_ready_o <= (gap == 2'h0);
        end else begin
            req_ready_o <= (credit_use < 3'(dbs_pkg::BUF_DEPTH));
        end
    end

    // turnaround and outstanding read bookkeeping
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap  <= 2'h0;
            pend <= 2'h0;
        end else begin
            if (issue && take_rd) begin
                gap <= 2'(dbs_pkg::RD_WR_GAP);
            end else if (issue && gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
            pend <= pend + {1'h0, take_rd} - {1'h0, push};
        end
    end

    // write data waits one period behind its command
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wpend <= 1'h0;
            wdata <= '0;
            wmask <= '1;
        end else if (issue) begin
            wpend <= take_wr;
            if (take_wr) begin
                wdata <= req_wdata_i;
                wmask <= req_mask_n_i;
            end
        end
    end

    // data bus drive: beat one on the clock rise, beat two half after
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.dq_host           <= '0;
            link.dq_host_oe        <= 1'h0;
            link.byte_write_mask_n <= '1;
            hi_data                <= '0;
            hi_mask                <= '1;
            bus                    <= dbs_pkg::BUS_IDLE;
        end else if (issue) begin
            if (wpend) begin
                link.dq_host           <= wdata[DW-1:0];
                link.byte_write_mask_n <= wmask[LN-1:0];
                link.dq_host_oe        <= 1'h1;
                hi_data                <= wdata[WW-1:DW];
                hi_mask                <= wmask[MW-1:LN];
                bus                    <= dbs_pkg::BUS_BEAT1;
            end else begin
                link.dq_host           <= '0;
                link.byte_write_mask_n <= '1;
                link.dq_host_oe        <= 1'h0;
                bus                    <= dbs_pkg::BUS_IDLE;
            end
        end else begin
            case (bus)
                dbs_pkg::BUS_BEAT1: begin
                    link.dq_host           <= hi_data;
                    link.byte_write_mask_n <= hi_mask;
                    bus                    <= dbs_pkg::BUS_BEAT2;
                end
                default: begin
                    link.dq_host_oe <= 1'h0;
                    bus             <= dbs_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // read return: pair beats while valid is high, low beat first
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hb      <= 1'h0;
            lo_beat <= '0;
        end else if (link.read_valid_out) begin
            if (!hb) begin
                lo_beat <= link.dq;
            end
            hb <= ~hb;
        end
    end

    // room was reserved at issue, so the buffer never refuses a word
    dbs_buf2 #(
        .W (WW)
    ) u_rsp_buf (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (push),
        .in_ready_o  (),
        .in_data_i   ({link.dq, lo_beat}),
        .out_valid_o (rsp_valid_o),
        .out_ready_i (rsp_ready_i),
        .out_data_o  (rsp_data_o),
        .count_o     (buf_cnt)
    );
endmodule : dbs_ctl
`default_nettype wire

// File: tb/dbs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dbs_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_n,
    input wire logic read_not_write,
    input wire logic read_valid_out,
    input wire logic dq_host_oe,
    input wire logic dq_dev_oe
);
    logic       rd_cmd;
    logic       wr_cmd;
    logic [7:0] rv_run;
    logic [3:0] idle_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // command decode as the device end sees it
    assign rd_cmd = !load_n && read_not_write;
    assign wr_cmd = !load_n && !read_not_write;

    // run length of read valid; an odd run means a beat went missing
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rv_run <= 8'h00;
        end else begin
            rv_run <= read_valid_out ? rv_run + 8'h01 : 8'h00;
        end
    end

    // cycles since the last command, saturating
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idle_cnt <= 4'h0;
        end else if (!load_n) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    a_valid_marks_drive: assert property (read_valid_out == dq_dev_oe)
        else $error("read valid and device drive differ");
    a_read_latency: assert property (
        rd_cmd && k && !$past(k) |-> ##[3:5] read_valid_out)
        else $error("read data late");
    a_read_cause: assert property (
        $rose(read_valid_out) |-> $past(rd_cmd, 4) || $past(rd_cmd, 5))
        else $error("read data without read command");
    a_even_beats: assert property (
        $fell(read_valid_out) |-> !rv_run[0])
        else $error("odd number of read beats");
    a_no_contend: assert property (!(dq_host_oe && dq_dev_oe))
        else $error("both ends drive data");
    a_turn_gap: assert property (
        $rose(dq_host_oe) |-> !$past(dq_dev_oe))
        else $error("host drives right after device");
    a_link_clocks: assert property (
        $past(rstn_i) |-> k != $past(k) && k_n != k)
        else $error("link clocks not toggling as a pair");
    a_write_data: assert property (
        wr_cmd && k && !$past(k) |-> ##2 dq_host_oe)
        else $error("write data not on time");
    a_write_beats: assert property (
        $rose(dq_host_oe) |-> ##1 dq_host_oe)
        else $error("write burst shorter than two beats");
    a_idle_quiet: assert property (
        idle_cnt == 4'hF |-> !read_valid_out && !dq_dev_oe)
        else $error("device drives while deselected");

    c_read: cover property ($rose(read_valid_out));
    c_read_pair: cover property (read_valid_out [*4]);
    c_write: cover property ($rose(dq_host_oe));
endmodule : dbs_properties
`default_nettype wire

// File: tb/ddr_burst2_sram_interface_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_burst2_sram_interface_bench;
    logic                       clk_i;
    logic                       rstn_i;
    logic                       req_valid_i;
    logic                       req_write_i;
    logic [dbs_pkg::ADDR_W-1:0] req_addr_i;
    logic [dbs_pkg::WORD_W-1:0] req_wdata_i;
    logic [dbs_pkg::MASK_W-1:0] req_mask_n_i;
    logic                       dll_enable_i;
    logic                       odt_enable_i;
    logic                       rsp_ready_i;
    logic                       req_ready_o;
    logic                       rsp_valid_o;
    logic [dbs_pkg::WORD_W-1:0] rsp_data_o;
    logic                       dll_active_o;
    logic                       dq_term_on_o;
    logic                       stall_on;
    logic [dbs_pkg::WORD_W-1:0] shadow [dbs_pkg::MEM_DEPTH];
    logic [dbs_pkg::WORD_W-1:0] exp_q [$];
    int                         failures;
    int                         samples_checked;
    int                         seed;
    int                         n;

    dbs_if link_if ();
    dbs_sram_dev dbs_sram_dev_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .link(link_if), .dll_active_o(dll_active_o),
        .dq_term_on_o(dq_term_on_o));
    dbs_ctl dbs_ctl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link_if),
        .req_valid_i(req_valid_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_mask_n_i(req_mask_n_i), .dll_enable_i(dll_enable_i),
        .odt_enable_i(odt_enable_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_ready_i(rsp_ready_i));
    dbs_properties dbs_properties_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .k(link_if.k), .k_n(link_if.k_n), .load_n(link_if.load_n),
        .read_not_write(link_if.read_not_write),
        .read_valid_out(link_if.read_valid_out),
        .dq_host_oe(link_if.dq_host_oe), .dq_dev_oe(link_if.dq_dev_oe));

    // 200 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp || $isunknown(got)) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [35:0] rnd();
        return 36'({$random(seed), $random(seed)});
    endfunction : rnd

    // masked lanes keep the old contents
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] d,
                                          logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            if (!m[i]) begin
                o[i*9 +: 9] = d[i*9 +: 9];
            end
        end
        return o;
    endfunction : merge

    // a direction change drops valid one cycle, since ready looks back
    task automatic issue(input logic wr, input int a, input logic [35:0] d,
                         input logic [3:0] m);
        int w;
        if (wr !== req_write_i) begin
            req_valid_i = 1'b0;
            req_write_i = wr;
            @(posedge clk_i);
            #1;
        end
        req_valid_i  = 1'b1;
        req_addr_i   = a[5:0];
        req_wdata_i  = d;
        req_mask_n_i = m;
        w = 0;
        do begin
            @(negedge clk_i);
            w++;
        end while (req_ready_o !== 1'b1 && w < 300);
        if (w >= 300) begin
            failures++;
        end
        @(posedge clk_i);
        #1;
        if (wr) begin
            shadow[a] = merge(shadow[a], d, m);
        end else begin
            exp_q.push_back(shadow[a]);
        end
    endtask : issue

    task automatic idle(input int c);
        req_valid_i = 1'b0;
        repeat (c) @(posedge clk_i);
        #1;
    endtask : idle

    // consumer stalls at random; checked just before the taking edge
    always @(posedge clk_i) begin
        #1;
        rsp_ready_i = stall_on ? 1'b0 : (($random(seed) & 3) != 0);
    end
    always @(negedge clk_i) begin
        if (rstn_i && rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(rsp_data_o, 36'hX);
            end else begin
                check(rsp_data_o, exp_q.pop_front());
            end
        end
    end

    // under 1000 cycles of traffic; thirty times that means a hang
    initial begin
        #(30000 * 5);
        failures++;
        end_of_test();
    end

    initial begin
        seed = 84108;
        failures = 0;
        samples_checked = 0;
        {rstn_i, req_valid_i, req_write_i, dll_enable_i} = 4'h0;
        odt_enable_i = 1'b0;
        {req_addr_i, req_wdata_i, req_mask_n_i} = '0;
        stall_on = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        dll_enable_i = 1'b1;
        odt_enable_i = 1'b1;
        idle(4);
        check(36'(dll_active_o), 36'h1);
        check(36'(dq_term_on_o), 36'h1);
        stall_on = 1'b0;
        for (int a = 0; a < dbs_pkg::MEM_DEPTH; a++) begin
            issue(1'b1, a, rnd(), 4'h0);
        end
        // every mask pattern, read straight back
        for (int m = 0; m < 16; m++) begin
            issue(1'b1, m, rnd(), m[3:0]);
            issue(1'b0, m, '0, 4'hF);
        end
        for (int i = 0; i < 80; i++) begin
            issue(1'(($random(seed) & 1) == 1), $random(seed) & 63, rnd(),
                  4'($random(seed)));
            if (($random(seed) & 3) == 0) begin
                idle(($random(seed) & 7) + 1);
            end
        end
        // full return buffer refuses a third read until drained
        idle(20);
        stall_on = 1'b1;
        issue(1'b0, 1, '0, 4'hF);
        issue(1'b0, 2, '0, 4'hF);
        n = 0;
        repeat (20) begin
            @(negedge clk_i);
            n += int'(req_ready_o === 1'b1);
        end
        check(36'(n), 36'h0);
        @(posedge clk_i);
        #1;
        stall_on = 1'b0;
        issue(1'b0, 3, '0, 4'hF);
        dll_enable_i = 1'b0;
        odt_enable_i = 1'b0;
        idle(40);
        check(36'(exp_q.size()), 36'h0);
        check(36'(dll_active_o), 36'h0);
        check(36'(dq_term_on_o), 36'h0);
        end_of_test();
    end
endmodule : ddr_burst2_sram_interface_bench
`default_nettype wire
